//--- regs_pkg.sv
// Package with register map, field layout and carrier types
package regs_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  localparam logic [5:0] OFF_CNT_LO   = 6'h18;
  localparam logic [5:0] OFF_CNT_HI   = 6'h19;
  localparam logic [5:0] OFF_TEMP     = 6'h20;
  localparam logic [5:0] OFF_USER0    = 6'h28;
  localparam logic [5:0] OFF_USER1    = 6'h29;
  localparam logic [5:0] OFF_CONFIG   = 6'h30;
  localparam logic [5:0] OFF_XOFFSET  = 6'h31;
  localparam logic [5:0] OFF_XTEMPCO  = 6'h32;
  localparam logic [5:0] OFF_XTURN    = 6'h33;

  localparam int unsigned POS_RES_80K  = 7;
  localparam int unsigned POS_RES_20K  = 6;
  localparam int unsigned POS_RES_5K   = 5;
  localparam int unsigned POS_RES_1K5  = 4;
  localparam int unsigned POS_FSEL_HI  = 3;
  localparam int unsigned POS_FSEL_LO  = 2;
  localparam int unsigned POS_THERM_EN = 1;
  localparam int unsigned POS_PERIOD   = 0;
  localparam int unsigned POS_SIGN     = 7;

  localparam logic [7:0] TURN_MASK     = 8'h3f;
  localparam logic [7:0] RST_COUNT     = 8'h00;
  localparam logic [7:0] RST_TEMP      = 8'h3c;
  localparam logic [7:0] RST_USER      = 8'h00;
  localparam logic [7:0] TEMP_ZERO_C   = 8'h3c;
  localparam logic [7:0] TEMP_MAX_CODE = 8'hfa;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       busy;
    logic [5:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic       res_80k;
    logic       res_20k;
    logic       res_5k;
    logic       res_1k5;
    logic [1:0] freq_sel;
    logic       therm_en;
    logic       period;
  } config_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] offset;
    logic [7:0] tempco;
    logic [7:0] turnover;
  } nv_image_t;
endpackage : regs_pkg

//--- temp_cache.sv
// Temperature result holder with access freeze and host override
`timescale 1ns/10ps
module temp_cache
  import regs_pkg::*;
(
  input  wire logic       clk,        // Crystal clock
  input  wire logic       rst_n,      // Sync reset, low
  input  wire logic       ce,         // Clock enable
  input  wire logic       therm_en,   // Thermometer enabled
  input  wire logic       meas_valid, // New measurement pulse
  input  wire logic [7:0] meas_code,  // Measured code
  input  wire logic       busy,       // Host access in progress
  input  wire logic       host_wr,    // Host write to temperature
  input  wire logic [7:0] host_data,  // Host write data
  output logic      [7:0] temp_value  // Value seen by the host
);
  import regs_pkg::*;

  logic [7:0] live_q, live_d;
  logic [7:0] frozen_q, frozen_d;
  logic       busy_q, busy_d;

  function automatic logic [7:0] clamp_code(input logic [7:0] c);
    clamp_code = (c > TEMP_MAX_CODE) ? TEMP_MAX_CODE : c; // see (RL2)
  endfunction : clamp_code

  always_comb begin
    live_d = live_q;
    if (therm_en && meas_valid) begin
      live_d = clamp_code(meas_code);               // see (RL4)
    end else if (!therm_en && host_wr) begin
      live_d = host_data;                           // see (RL4)
    end
    busy_d   = busy;
    // Snapshot taken on the first busy cycle, held until access ends
    frozen_d = (busy && !busy_q) ? live_q : frozen_q; // see (RL3)
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      live_q   <= RST_TEMP;
      frozen_q <= RST_TEMP;
      busy_q   <= 1'b0;
    end else if (ce) begin
      live_q   <= live_d;
      frozen_q <= frozen_d;
      busy_q   <= busy_d;
    end
  end

  assign temp_value = busy_q ? frozen_q : live_q; // see (RL3)
endmodule : temp_cache

//--- nv_ctrl_page.sv
// Non-volatile configuration and calibration bytes
`timescale 1ns/10ps
module nv_ctrl_page
  import regs_pkg::*;
(
  input  wire logic      clk,      // Crystal clock
  input  wire logic      rst_n,    // Sync reset, low
  input  wire logic      ce,       // Clock enable
  input  wire nv_image_t nv_in,    // Stored non-volatile image
  input  wire logic      wr,       // Host write strobe
  input  wire logic [5:0] addr,    // Host address
  input  wire logic [7:0] wdata,   // Host write data
  output nv_image_t      nv_out    // Current bytes
);
  import regs_pkg::*;

  nv_image_t img_q, img_d;
  logic      load_q, load_d;

  always_comb begin
    img_d  = img_q;
    load_d = 1'b0;
    if (load_q) begin
      img_d = nv_in;                                 // see (RL17)
      img_d.turnover = nv_in.turnover & TURN_MASK;   // see (RL16)
    end else if (wr) begin
      // Calibration stays writable; keeping it intact is software's duty
      if (addr == OFF_CONFIG) begin
        img_d.cfg = wdata;                           // see (RL6)
      end else if (addr == OFF_XOFFSET) begin
        img_d.offset = wdata;                        // see (RL11) (RL15)
      end else if (addr == OFF_XTEMPCO) begin
        img_d.tempco = wdata;                        // see (RL12)
      end else if (addr == OFF_XTURN) begin
        img_d.turnover = wdata & TURN_MASK;          // see (RL13) (RL16)
      end
    end
  end

  // Reload from the stored image on the first enabled edge after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      img_q  <= '0;
      load_q <= 1'b1;
    end else if (ce) begin
      img_q  <= img_d;
      load_q <= load_d;
    end
  end

  assign nv_out = img_q; // see (RL10) (RL14)
endmodule : nv_ctrl_page

//--- rtc_timer_temp_eeprom_regs.sv
// Register bank: countdown reload, temperature, user and control bytes
// Summary of operation
// (RL1) Countdown reload is 16 bits: low byte at 18h, high at 19h.
// (RL2) Temperature byte is unsigned with offset sixty; 0..250 is -60..+190 C.
// (RL3) A frozen copy of temperature is read during any host access.
// (RL4) Host may write temperature at 20h only while thermometer is off.
// (RL5) Two non-volatile user bytes at 28h and 29h, any value.
// (RL6) Control page: configuration at 30h then three calibration bytes.
// (RL7) Config bits 7..4 enable the 80k, 20k, 5k, 1.5k trickle resistors.
// (RL8) Config bits 3..2 select clock output frequency, all codes valid.
// (RL9) Config bit 1 enables thermometer, bit 0 picks measurement period.
// (RL10) Bytes 31h..33h hold crystal calibration for compensation.
// (RL11) Offset byte is sign-magnitude: bit 7 fast, bits 6..0 magnitude.
// (RL12) Temperature coefficient byte is unsigned 0..255.
// (RL13) Turnover byte uses bits 5..0 in degrees, bits 7..6 unused.
// (RL14) Offset byte is factory set for the fitted crystal.
// (RL15) Host must not alter the three calibration bytes; host writes to 31h..33h still update them here.
// (RL16) Unused turnover bits ignore writes and read as zero.
// (RL17) Config and calibration reload from stored image after reset.
`timescale 1ns/10ps
module rtc_timer_temp_eeprom_regs
  import regs_pkg::*;
(
  input  wire logic       clk,                 // 32.768 kHz crystal clock
  input  wire logic       rst_n,               // Sync power-up reset, low
  input  wire logic       ce,                  // Clock enable, freezes state
  input  wire host_req_t  req,                 // Host access from serial interface
  output logic      [7:0] rdata,               // Read data, registered
  input  wire logic       meas_valid,          // Thermometer result pulse
  input  wire logic [7:0] meas_code,           // Thermometer result code
  input  wire nv_image_t  nv_image,            // Stored non-volatile control image
  input  wire logic [7:0] nv_user0,            // Stored user byte 0
  input  wire logic [7:0] nv_user1,            // Stored user byte 1
  output logic [15:0]     countdown_reload,    // Timer reload value
  output logic            trickle_res_80k_en,  // 80k trickle resistor
  output logic            trickle_res_20k_en,  // 20k trickle resistor
  output logic            trickle_res_5k_en,   // 5k trickle resistor
  output logic            trickle_res_1k5_en,  // 1.5k trickle resistor
  output logic            clk_out_freq_sel_hi, // Clock output select high
  output logic            clk_out_freq_sel_lo, // Clock output select low
  output logic            therm_enable,        // Thermometer enable
  output logic            temp_sample_period,  // Measurement period select
  output logic      [7:0] temperature_result,  // Current temperature code
  output logic      [7:0] crystal_offset_cal,  // Offset calibration
  output logic      [7:0] crystal_tempco_cal,  // Tempco calibration
  output logic      [7:0] crystal_turnover_cal // Turnover calibration
);
  import regs_pkg::*;

  logic [7:0] cnt_lo_q, cnt_lo_d;
  logic [7:0] cnt_hi_q, cnt_hi_d;
  logic [7:0] user0_q, user0_d;
  logic [7:0] user1_q, user1_d;
  logic       uload_q, uload_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] temp_value;
  nv_image_t  nv_cur;
  config_t    cfg;
  logic       temp_wr;

  assign cfg     = config_t'(nv_cur.cfg);
  assign temp_wr = req.wr && (req.addr == OFF_TEMP);

  temp_cache u_temp (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .therm_en   (cfg.therm_en),
    .meas_valid (meas_valid),
    .meas_code  (meas_code),
    .busy       (req.busy),
    .host_wr    (temp_wr),
    .host_data  (req.wdata),
    .temp_value (temp_value)
  );

  nv_ctrl_page u_nv (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .nv_in  (nv_image),
    .wr     (req.wr),
    .addr   (req.addr),
    .wdata  (req.wdata),
    .nv_out (nv_cur)
  );

  // Timer, user bytes and read path
  always_comb begin
    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    user0_d  = user0_q;
    user1_d  = user1_q;
    uload_d  = 1'b0;
    rdata_d  = rdata_q;
    if (uload_q) begin
      user0_d = nv_user0;                              // see (RL5)
      user1_d = nv_user1;
    end else if (req.wr) begin
      if (req.addr == OFF_CNT_LO) begin
        cnt_lo_d = req.wdata;                          // see (RL1)
      end else if (req.addr == OFF_CNT_HI) begin
        cnt_hi_d = req.wdata;                          // see (RL1)
      end else if (req.addr == OFF_USER0) begin
        user0_d = req.wdata;                           // see (RL5)
      end else if (req.addr == OFF_USER1) begin
        user1_d = req.wdata;                           // see (RL5)
      end
    end
    if (req.rd) begin
      if (req.addr == OFF_CNT_LO) begin
        rdata_d = cnt_lo_q;
      end else if (req.addr == OFF_CNT_HI) begin
        rdata_d = cnt_hi_q;
      end else if (req.addr == OFF_TEMP) begin
        rdata_d = temp_value;                          // see (RL3)
      end else if (req.addr == OFF_USER0) begin
        rdata_d = user0_q;
      end else if (req.addr == OFF_USER1) begin
        rdata_d = user1_q;
      end else if (req.addr == OFF_CONFIG) begin
        rdata_d = nv_cur.cfg;
      end else if (req.addr == OFF_XOFFSET) begin
        rdata_d = nv_cur.offset;
      end else if (req.addr == OFF_XTEMPCO) begin
        rdata_d = nv_cur.tempco;
      end else if (req.addr == OFF_XTURN) begin
        rdata_d = nv_cur.turnover & TURN_MASK;         // see (RL16)
      end else begin
        // Pages outside this bank read as zero here
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_lo_q <= RST_COUNT;
      cnt_hi_q <= RST_COUNT;
      user0_q  <= RST_USER;
      user1_q  <= RST_USER;
      uload_q  <= 1'b1;
      rdata_q  <= 8'h00;
    end else if (ce) begin
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
      user0_q  <= user0_d;
      user1_q  <= user1_d;
      uload_q  <= uload_d;
      rdata_q  <= rdata_d;
    end
  end

  assign rdata                = rdata_q;
  assign countdown_reload     = {cnt_hi_q, cnt_lo_q};  // see (RL1)
  assign trickle_res_80k_en   = cfg.res_80k;           // see (RL7)
  assign trickle_res_20k_en   = cfg.res_20k;           // see (RL7)
  assign trickle_res_5k_en    = cfg.res_5k;            // see (RL7)
  assign trickle_res_1k5_en   = cfg.res_1k5;           // see (RL7)
  assign clk_out_freq_sel_hi  = cfg.freq_sel[1];       // see (RL8)
  assign clk_out_freq_sel_lo  = cfg.freq_sel[0];       // see (RL8)
  assign therm_enable         = cfg.therm_en;          // see (RL9)
  assign temp_sample_period   = cfg.period;            // see (RL9)
  assign temperature_result   = temp_value;            // see (RL2)
  assign crystal_offset_cal   = nv_cur.offset;         // see (RL10) (RL11)
  assign crystal_tempco_cal   = nv_cur.tempco;         // see (RL10) (RL12)
  assign crystal_turnover_cal = nv_cur.turnover;       // see (RL10) (RL13)
endmodule : rtc_timer_temp_eeprom_regs

//--- regs_props.sv
// Assertions on register bank ports
`timescale 1ns/10ps
module regs_props
  import regs_pkg::*;
(
  input wire logic        clk,                  // Clock
  input wire logic        rst_n,                // Reset, low
  input wire logic        ce,                   // Enable
  input wire host_req_t   req,                  // Host access
  input wire logic [7:0]  rdata,                // Read data
  input wire nv_image_t   nv_image,             // Stored image
  input wire logic [15:0] countdown_reload,     // Reload
  input wire logic        trickle_res_80k_en,   // Cfg 7
  input wire logic        trickle_res_20k_en,   // Cfg 6
  input wire logic        trickle_res_5k_en,    // Cfg 5
  input wire logic        trickle_res_1k5_en,   // Cfg 4
  input wire logic        clk_out_freq_sel_hi,  // Cfg 3
  input wire logic        clk_out_freq_sel_lo,  // Cfg 2
  input wire logic        therm_enable,         // Cfg 1
  input wire logic        temp_sample_period,   // Cfg 0
  input wire logic [7:0]  temperature_result,   // Temperature
  input wire logic [7:0]  crystal_offset_cal,   // Offset
  input wire logic [7:0]  crystal_tempco_cal,   // Tempco
  input wire logic [7:0]  crystal_turnover_cal  // Turnover
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic live_q;
  logic live_d;
  // Host writes on the image load edge are lost, so skip that edge
  always_comb live_d = live_q | ce;
  always_ff @(posedge clk) live_q <= rst_n ? live_d : 1'b0;
  wire logic wr_ok = live_q && ce && req.wr;
  wire logic rd_ok = live_q && ce && req.rd;
  wire logic [7:0] cfg_o = {trickle_res_80k_en, trickle_res_20k_en, trickle_res_5k_en, trickle_res_1k5_en,
                            clk_out_freq_sel_hi, clk_out_freq_sel_lo, therm_enable, temp_sample_period};
  property p_lo; wr_ok && req.addr == OFF_CNT_LO |=> countdown_reload[7:0] == $past(req.wdata); endproperty
  a_lo: assert property (p_lo) else $error("reload low byte not written");
  property p_hi; wr_ok && req.addr == OFF_CNT_HI |=> countdown_reload[15:8] == $past(req.wdata); endproperty
  a_hi: assert property (p_hi) else $error("reload high byte not written");
  property p_rdhi; rd_ok && req.addr == OFF_CNT_HI |=> rdata == 8'($past(countdown_reload) >> 8); endproperty
  a_rdhi: assert property (p_rdhi) else $error("reload high byte read wrong");
  property p_cfg; wr_ok && req.addr == OFF_CONFIG |=> cfg_o == $past(req.wdata); endproperty
  a_cfg: assert property (p_cfg) else $error("config bits not mapped");
  property p_frz; ce && req.busy && !req.wr ##1 ce && req.busy && !req.wr |=> $stable(temperature_result); endproperty
  a_frz: assert property (p_frz) else $error("temperature moved during access");
  property p_turn; crystal_turnover_cal[7:6] == 2'b00; endproperty
  a_turn: assert property (p_turn) else $error("turnover unused bits set");
  property p_load; ce && !live_q |=> crystal_offset_cal == $past(nv_image.offset)
    && crystal_tempco_cal == $past(nv_image.tempco); endproperty
  a_load: assert property (p_load) else $error("calibration not loaded from image");
  property p_rdturn; rd_ok && req.addr == OFF_XTURN |=> rdata == ($past(crystal_turnover_cal) & TURN_MASK); endproperty
  a_rdturn: assert property (p_rdturn) else $error("turnover read wrong");
  property p_unmap; rd_ok && req.addr == 6'h34 |=> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("read past control page not zero");
endmodule : regs_props
bind rtc_timer_temp_eeprom_regs regs_props regs_props_i (.clk, .rst_n, .ce, .req, .rdata, .nv_image,
  .countdown_reload, .trickle_res_80k_en, .trickle_res_20k_en, .trickle_res_5k_en, .trickle_res_1k5_en,
  .clk_out_freq_sel_hi, .clk_out_freq_sel_lo, .therm_enable, .temp_sample_period, .temperature_result,
  .crystal_offset_cal, .crystal_tempco_cal, .crystal_turnover_cal);

//--- host_model.sv
// Host controller model driving register accesses
`timescale 1ns/10ps
module host_model
  import regs_pkg::*;
(
  input  wire logic       clk,   // Clock
  input  wire logic [7:0] rdata, // Read data
  output host_req_t       req    // Host access
);
  initial req = '{rd:1'b0, wr:1'b0, busy:1'b0, addr:6'h00, wdata:8'h00};
  task automatic access(input logic r, input logic [5:0] a, input logic [7:0] d, input int hold);
    @(posedge clk);
    req <= '{rd:r, wr:!r, busy:1'b1, addr:a, wdata:d};
    @(posedge clk);
    req <= '{rd:1'b0, wr:1'b0, busy:1'b1, addr:a, wdata:d};
    repeat (hold) @(posedge clk);
    @(posedge clk);
    // Released lines show inverted leftovers so stale values never match
    req <= '{rd:1'b0, wr:1'b0, busy:1'b0, addr:~a, wdata:~d};
  endtask : access
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a inside {OFF_XOFFSET, OFF_XTEMPCO, OFF_XTURN}) return;
    access(1'b0, a, d, 0);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d, input int hold);
    access(1'b1, a, 8'h00, hold);
    d = rdata;
  endtask : rd
endmodule : host_model

//--- tb.sv
// Self-checking bench for the register bank
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  import regs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic meas_valid = 1'b0;
  logic [7:0] meas_code = 8'h00;
  nv_image_t nv_image = '{cfg:8'h5a, offset:8'h85, tempco:8'hc3, turnover:8'hff};
  logic [7:0] nv_user0 = 8'h12;
  logic [7:0] nv_user1 = 8'h34;
  host_req_t req;
  wire [7:0] rdata, temperature_result, crystal_offset_cal, crystal_tempco_cal, crystal_turnover_cal, cfg_o;
  wire [15:0] countdown_reload;
  logic [7:0] d;
  logic [7:0] v;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [5:0] ra [6] = '{OFF_USER0, OFF_USER1, OFF_XOFFSET, OFF_XTEMPCO, OFF_XTURN, 6'h34};
  logic [7:0] re [6] = '{8'h12, 8'h34, 8'h85, 8'hc3, 8'h3f, 8'h00};
  rtc_timer_temp_eeprom_regs rtc_timer_temp_eeprom_regs_i (.clk, .rst_n, .ce, .req, .rdata, .meas_valid,
    .meas_code, .nv_image, .nv_user0, .nv_user1, .countdown_reload, .trickle_res_80k_en(cfg_o[7]),
    .trickle_res_20k_en(cfg_o[6]), .trickle_res_5k_en(cfg_o[5]), .trickle_res_1k5_en(cfg_o[4]),
    .clk_out_freq_sel_hi(cfg_o[3]), .clk_out_freq_sel_lo(cfg_o[2]), .therm_enable(cfg_o[1]),
    .temp_sample_period(cfg_o[0]), .temperature_result, .crystal_offset_cal, .crystal_tempco_cal,
    .crystal_turnover_cal);
  host_model host_model_i (.clk, .rdata, .req);
  always #20 clk = ~clk;
  task automatic summarize;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // Run needs about 110 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("cfg", 8'h5a, cfg_o)
    `CHK("offset", 8'h85, crystal_offset_cal)
    `CHK("tempco", 8'hc3, crystal_tempco_cal)
    `CHK("turnover", 8'h3f, crystal_turnover_cal)
    foreach (ra[i]) begin
      host_model_i.rd(ra[i], d, 0);
      `CHK("read", re[i], d)
    end
    host_model_i.wr(OFF_CNT_LO, 8'hff);
    host_model_i.wr(OFF_CNT_HI, 8'h01);
    `CHK("reload", 16'h01ff, countdown_reload)
    host_model_i.rd(OFF_CNT_HI, d, 0);
    `CHK("reload high", 8'h01, d)
    host_model_i.wr(OFF_USER0, 8'hff);
    host_model_i.wr(OFF_USER1, 8'h00);
    // A write while the enable is low must leave no trace
    ce <= 1'b0;
    host_model_i.wr(OFF_USER0, 8'h55);
    ce <= 1'b1;
    host_model_i.rd(OFF_USER0, d, 0);
    `CHK("user0", 8'hff, d)
    host_model_i.rd(OFF_USER1, d, 0);
    `CHK("user1", 8'h00, d)
    for (int i = 0; i < 9; i++) begin
      v = (i < 8) ? 8'h01 << i : 8'h0c;
      host_model_i.wr(OFF_CONFIG, v);
      `CHK("cfg", v, cfg_o)
    end
    host_model_i.wr(OFF_TEMP, 8'hfa);
    // Frozen copy is shown until busy has dropped, so look at the live value after
    repeat (2) @(posedge clk);
    `CHK("temp", 8'hfa, temperature_result)
    host_model_i.rd(OFF_TEMP, d, 0);
    `CHK("temp read", 8'hfa, d)
    host_model_i.wr(OFF_CONFIG, 8'h02);
    host_model_i.wr(OFF_TEMP, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("temp", 8'hfa, temperature_result)
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_code <= TEMP_ZERO_C;
    @(posedge clk);
    meas_valid <= 1'b0;
    @(posedge clk);
    `CHK("temp", 8'h3c, temperature_result)
    fork
      host_model_i.rd(OFF_TEMP, d, 4);
      begin
        repeat (2) @(posedge clk);
        meas_valid <= 1'b1;
        meas_code <= 8'hff;
        @(posedge clk);
        meas_valid <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("frozen", 8'h3c, temperature_result)
      end
    join
    `CHK("frozen read", 8'h3c, d)
    repeat (2) @(posedge clk);
    `CHK("temp", 8'hfa, temperature_result)
    summarize();
  end
endmodule : tb
